// ### hw/exec_cfg.svh
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
// Operation
// RQ1: store to z pointer plus displacement takes two cycles, flags untouched
// RQ2: store to direct address from the instruction completes in two cycles
// RQ3: push register to stack takes two cycles, flags untouched
// RQ4: pop stack entry into register takes two cycles, flags untouched
// RQ5: io bit set forces one bit to one in two cycles, rest untouched
// RQ6: io bit clear forces one bit to zero in two cycles, rest untouched
// RQ7: logical left shift, zero into bit 0, updates z c n v, one cycle
// RQ8: logical right shift, zero into bit 7, updates z c n v, one cycle
// RQ9: left rotate through carry in one cycle, updates z c n v
// RQ10: right rotate through carry in one cycle, updates z c n v
// RQ11: arithmetic right shift keeps bit 7, one cycle, updates z c n v
// RQ12: bit store copies selected source bit into t flag only, one cycle
// RQ13: bit load copies t flag into selected destination bit, one cycle
// RQ14: single cycle set and clear of overflow flag only
// RQ15: single cycle set and clear of half carry flag only
// RQ16: single cycle set and clear of signed test flag only
// RQ17: sleep issues in one cycle, flags untouched, enters low power state

// status flag bit positions
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

// z pointer register pair
`define ZPTR_LO 30
`define ZPTR_HI 31

// reset values
`define FLAGS_RESET 8'h00
`define REG_RESET 8'h00
`define SP_RESET 16'h007f
`endif

// ### hw/exec_pkg.sv
package exec_pkg;
  typedef enum logic [4:0] {
    op_nop, store_displaced, store_direct, op_push, op_pop,
    io_bit_set_op, io_bit_clear_op, shift_left_logical, shift_right_logical,
    rotate_left_carry, rotate_right_carry, shift_right_arith,
    bit_to_flag_op, flag_to_bit_op, overflow_set_op, overflow_clear_op,
    halfcarry_set_op, halfcarry_clear_op, signtest_set_op, signtest_clear_op,
    flag_set_op, flag_clear_op, op_sleep
  } op_t;

  typedef enum logic [2:0] {
    st_issue = 3'b001,
    st_second = 3'b010,
    st_sleep = 3'b100
  } state_t;

  typedef struct packed {
    op_t op;
    logic [4:0] dst;
    logic [4:0] src;
    logic [2:0] bitsel;
    logic [5:0] disp;
    logic [15:0] addr;
  } instr_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [2:0] bitsel;
    logic value;
  } io_bit_t;

  typedef struct packed {
    logic [7:0] data;
    logic c;
    logic v;
    logic n;
    logic z;
  } shift_res_t;
endpackage

// ### hw/shift_unit.sv
`timescale 1ns/100ps
module shift_unit (
  input wire exec_pkg::op_t i_op,
  input wire logic [7:0] i_data,
  input wire logic i_carry,
  output exec_pkg::shift_res_t o_res
);
  import exec_pkg::*;

  always_comb begin
    o_res.c = 1'b0;
    o_res.data = i_data;
    case (i_op)
      shift_left_logical: begin
        o_res.data = {i_data[6:0], 1'b0};
        o_res.c = i_data[7];
      end
      shift_right_logical: begin
        o_res.data = {1'b0, i_data[7:1]};
        o_res.c = i_data[0];
      end
      rotate_left_carry: begin
        o_res.data = {i_data[6:0], i_carry};
        o_res.c = i_data[7];
      end
      rotate_right_carry: begin
        o_res.data = {i_carry, i_data[7:1]};
        o_res.c = i_data[0];
      end
      shift_right_arith: begin
        o_res.data = {i_data[7], i_data[7:1]};
        o_res.c = i_data[0];
      end
      default: begin
        o_res.data = i_data;
        o_res.c = i_carry;
      end
    endcase
    o_res.n = o_res.data[7];
    o_res.z = (o_res.data == 8'h00);
    // overflow after a shift is sign xor carry
    o_res.v = o_res.n ^ o_res.c;
  end
endmodule

// ### hw/flag_unit.sv
`timescale 1ns/100ps
`include "exec_cfg.svh"
module flag_unit (
  input wire exec_pkg::op_t i_op,
  input wire logic [7:0] i_status,
  input wire logic [2:0] i_index,
  input wire logic i_tbit,
  output logic [7:0] o_status
);
  import exec_pkg::*;

  always_comb begin
    o_status = i_status;
    case (i_op)
      overflow_set_op: o_status[`FLAG_V] = 1'b1; // see RQ14
      overflow_clear_op: o_status[`FLAG_V] = 1'b0; // see RQ14
      halfcarry_set_op: o_status[`FLAG_H] = 1'b1; // see RQ15
      halfcarry_clear_op: o_status[`FLAG_H] = 1'b0; // see RQ15
      signtest_set_op: o_status[`FLAG_S] = 1'b1; // see RQ16
      signtest_clear_op: o_status[`FLAG_S] = 1'b0; // see RQ16
      bit_to_flag_op: o_status[`FLAG_T] = i_tbit; // see RQ12
      flag_set_op: o_status[i_index] = 1'b1;
      flag_clear_op: o_status[i_index] = 1'b0;
      default: o_status = i_status;
    endcase
  end
endmodule

// ### hw/mcu_bit_and_store_instr_exec.sv
`timescale 1ns/100ps
`include "exec_cfg.svh"
module mcu_bit_and_store_instr_exec (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_issue,
  input wire exec_pkg::instr_t i_instr,
  output logic o_ready,
  input wire logic [7:0] i_mem_rdata,
  output exec_pkg::mem_req_t o_mem,
  output exec_pkg::io_bit_t o_io,
  input wire logic i_wake,
  output logic o_sleep,
  output logic [7:0] o_status,
  output logic [15:0] o_sp,
  input wire logic [4:0] i_peek_sel,
  output logic [7:0] o_peek_data
);
  import exec_pkg::*;

  state_t state_r;
  state_t state_nxt;
  instr_t instr_r;
  mem_req_t mem_r;
  io_bit_t io_r;
  logic [7:0] regs_r [0:31];
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [15:0] sp_r;
  logic sleep_r;
  logic [7:0] peek_r;
  logic accept;
  logic [7:0] dst_val;
  logic [7:0] src_val;
  logic [15:0] zptr;
  shift_res_t sh_res;
  logic is_shift;
  logic is_two;
  logic [7:0] flag_status;

  function automatic logic op_is_shift(input op_t op);
    op_is_shift = (op == shift_left_logical) || (op == shift_right_logical) ||
                  (op == rotate_left_carry) || (op == rotate_right_carry) ||
                  (op == shift_right_arith);
  endfunction

  function automatic logic op_is_two(input op_t op);
    op_is_two = (op == store_displaced) || (op == store_direct) ||
                (op == op_push) || (op == op_pop) ||
                (op == io_bit_set_op) || (op == io_bit_clear_op);
  endfunction

  assign o_ready = (state_r == st_issue);
  assign accept = i_issue && o_ready;
  assign dst_val = regs_r[i_instr.dst];
  assign src_val = regs_r[i_instr.src];
  assign zptr = {regs_r[`ZPTR_HI], regs_r[`ZPTR_LO]};
  assign is_shift = op_is_shift(i_instr.op);
  assign is_two = op_is_two(i_instr.op);
  assign o_mem = mem_r;
  assign o_io = io_r;
  assign o_sleep = sleep_r;
  assign o_status = status_r;
  assign o_sp = sp_r;
  assign o_peek_data = peek_r;

  shift_unit u_shift (
    .i_op(i_instr.op),
    .i_data(dst_val),
    .i_carry(status_r[`FLAG_C]),
    .o_res(sh_res)
  );

  flag_unit u_flag (
    .i_op(i_instr.op),
    .i_status(status_r),
    .i_index(i_instr.bitsel),
    .i_tbit(src_val[i_instr.bitsel]),
    .o_status(flag_status)
  );

  // sequencing: two cycle ops hold off the next issue for one cycle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      st_issue: begin
        if (accept && is_two) begin
          state_nxt = st_second;
        end else if (accept && i_instr.op == op_sleep) begin
          state_nxt = st_sleep; // see RQ17
        end
      end
      st_second: state_nxt = st_issue;
      st_sleep: begin
        if (i_wake) begin
          state_nxt = st_issue;
        end
      end
      default: state_nxt = st_issue;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_r <= st_issue;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      instr_r <= '0;
    end else if (accept) begin
      instr_r <= i_instr;
    end
  end

  // data memory request stands during the second cycle only
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mem_r <= '0;
    end else begin
      mem_r <= '0;
      if (accept) begin
        case (i_instr.op)
          store_displaced: begin
            mem_r.wr <= 1'b1;
            mem_r.addr <= zptr + {10'h000, i_instr.disp}; // see RQ1
            mem_r.wdata <= src_val;
          end
          store_direct: begin
            mem_r.wr <= 1'b1;
            mem_r.addr <= i_instr.addr; // see RQ2
            mem_r.wdata <= src_val;
          end
          op_push: begin
            mem_r.wr <= 1'b1;
            mem_r.addr <= sp_r; // see RQ3
            mem_r.wdata <= src_val;
          end
          op_pop: begin
            mem_r.rd <= 1'b1;
            mem_r.addr <= sp_r + 16'h0001; // see RQ4
          end
          default: mem_r <= '0;
        endcase
      end
    end
  end

  // io bit write stands during the second cycle only
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      io_r <= '0;
    end else begin
      io_r <= '0;
      if (accept && (i_instr.op == io_bit_set_op || i_instr.op == io_bit_clear_op)) begin
        io_r.we <= 1'b1;
        io_r.addr <= i_instr.addr[5:0];
        io_r.bitsel <= i_instr.bitsel;
        io_r.value <= (i_instr.op == io_bit_set_op); // see RQ5 see RQ6
      end
    end
  end

  // stack grows downward, push post-decrements, pop pre-increments
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sp_r <= `SP_RESET;
    end else if (accept && i_instr.op == op_push) begin
      sp_r <= sp_r - 16'h0001; // see RQ3
    end else if (accept && i_instr.op == op_pop) begin
      sp_r <= sp_r + 16'h0001; // see RQ4
    end
  end

  always_comb begin
    status_nxt = flag_status;
    if (is_shift) begin
      status_nxt[`FLAG_C] = sh_res.c; // see RQ7 see RQ8 see RQ9 see RQ10 see RQ11
      status_nxt[`FLAG_Z] = sh_res.z;
      status_nxt[`FLAG_N] = sh_res.n;
      status_nxt[`FLAG_V] = sh_res.v;
    end
  end

  // only single cycle flag and shift ops change the status flags
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      status_r <= `FLAGS_RESET;
    end else if (accept) begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 32; i++) begin
        regs_r[i] <= `REG_RESET;
      end
    end else if (state_r == st_second && instr_r.op == op_pop) begin
      regs_r[instr_r.dst] <= i_mem_rdata; // see RQ4
    end else if (accept && is_shift) begin
      regs_r[i_instr.dst] <= sh_res.data; // see RQ7 see RQ8 see RQ9 see RQ10 see RQ11
    end else if (accept && i_instr.op == flag_to_bit_op) begin
      regs_r[i_instr.dst][i_instr.bitsel] <= status_r[`FLAG_T]; // see RQ13
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sleep_r <= 1'b0;
    end else if (accept && i_instr.op == op_sleep) begin
      sleep_r <= 1'b1; // see RQ17
    end else if (state_r == st_sleep && i_wake) begin
      sleep_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      peek_r <= `REG_RESET;
    end else begin
      peek_r <= regs_r[i_peek_sel];
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  sequence busy_one;
    !o_ready ##1 o_ready;
  endsequence

  sequence flags_held_two;
    $stable(o_status) [*2];
  endsequence

  function automatic logic issued(input op_t op);
    issued = accept && (i_instr.op == op);
  endfunction

  property two_cycle_flagless(op_t op);
    issued(op) |=> busy_one and flags_held_two;
  endproperty

  store_disp_addr_a: assert property ( // see RQ1
    issued(store_displaced) |=> o_mem.wr &&
      o_mem.addr == $past(zptr) + {10'h000, $past(i_instr.disp)} &&
      o_mem.wdata == $past(src_val))
    else $error("displaced store address or data wrong");

  store_disp_time_a: assert property (two_cycle_flagless(store_displaced)) // see RQ1
    else $error("displaced store not two cycles or flags moved");

  store_direct_a: assert property ( // see RQ2
    issued(store_direct) |=> o_mem.wr && o_mem.addr == $past(i_instr.addr) ##1
      o_ready && !o_mem.wr)
    else $error("direct store not finished in two cycles");

  push_stack_a: assert property ( // see RQ3
    issued(op_push) |=> o_mem.wr && o_mem.addr == $past(o_sp) &&
      o_sp == $past(o_sp) - 16'h0001 ##0 busy_one and flags_held_two)
    else $error("push stack behaviour wrong");

  pop_stack_a: assert property ( // see RQ4
    issued(op_pop) |=> o_mem.rd && o_mem.addr == o_sp && !o_ready ##1
      o_ready && regs_r[instr_r.dst] == $past(i_mem_rdata) &&
      o_status == $past(o_status, 2))
    else $error("pop result, timing or flags wrong");

  io_set_a: assert property ( // see RQ5
    issued(io_bit_set_op) |=> o_io.we && o_io.value &&
      o_io.bitsel == $past(i_instr.bitsel) && o_io.addr == $past(i_instr.addr[5:0])
      ##0 flags_held_two)
    else $error("io bit set wrong");

  io_clear_a: assert property ( // see RQ6
    issued(io_bit_clear_op) |=> o_io.we && !o_io.value &&
      o_io.bitsel == $past(i_instr.bitsel) ##1 !o_io.we && o_ready)
    else $error("io bit clear wrong");

  shl_result_a: assert property ( // see RQ7
    issued(shift_left_logical) |=>
      regs_r[$past(i_instr.dst)] == {$past(dst_val[6:0]), 1'b0} &&
      o_status[`FLAG_C] == $past(dst_val[7]) && o_ready)
    else $error("logical left shift wrong");

  shr_result_a: assert property ( // see RQ8
    issued(shift_right_logical) |=>
      regs_r[$past(i_instr.dst)] == {1'b0, $past(dst_val[7:1])} &&
      o_status[`FLAG_C] == $past(dst_val[0]) && !o_status[`FLAG_N])
    else $error("logical right shift wrong");

  rol_carry_a: assert property ( // see RQ9
    issued(rotate_left_carry) |=>
      regs_r[$past(i_instr.dst)] == {$past(dst_val[6:0]), $past(o_status[`FLAG_C])} &&
      o_status[`FLAG_C] == $past(dst_val[7]))
    else $error("left rotate through carry wrong");

  ror_carry_a: assert property ( // see RQ10
    issued(rotate_right_carry) |=>
      regs_r[$past(i_instr.dst)] == {$past(o_status[`FLAG_C]), $past(dst_val[7:1])} &&
      o_status[`FLAG_C] == $past(dst_val[0]))
    else $error("right rotate through carry wrong");

  asr_sign_a: assert property ( // see RQ11
    issued(shift_right_arith) |=>
      regs_r[$past(i_instr.dst)] == {$past(dst_val[7]), $past(dst_val[7:1])} &&
      o_status[`FLAG_V] == (o_status[`FLAG_N] ^ o_status[`FLAG_C]) &&
      o_status[`FLAG_Z] == (regs_r[$past(i_instr.dst)] == 8'h00))
    else $error("arithmetic right shift wrong");

  shift_keeps_a: assert property ( // see RQ7
    accept && is_shift |=> o_status[7:4] == $past(o_status[7:4]))
    else $error("shift touched flags it must keep");

  bit_store_a: assert property ( // see RQ12
    issued(bit_to_flag_op) |=>
      o_status[`FLAG_T] == $past(src_val[i_instr.bitsel]) &&
      o_status[5:0] == $past(o_status[5:0]) && o_status[7] == $past(o_status[7]))
    else $error("bit store to t flag wrong");

  bit_load_a: assert property ( // see RQ13
    issued(flag_to_bit_op) |=>
      regs_r[$past(i_instr.dst)][$past(i_instr.bitsel)] == $past(o_status[`FLAG_T]) &&
      $stable(o_status))
    else $error("bit load from t flag wrong");

  overflow_ops_a: assert property ( // see RQ14
    accept && (i_instr.op == overflow_set_op || i_instr.op == overflow_clear_op) |=>
      o_status == (($past(o_status) & 8'hf7) |
      {4'h0, $past(i_instr.op) == overflow_set_op, 3'h0}) && o_ready)
    else $error("overflow flag op wrong");

  halfcarry_ops_a: assert property ( // see RQ15
    accept && (i_instr.op == halfcarry_set_op || i_instr.op == halfcarry_clear_op) |=>
      o_status == (($past(o_status) & 8'hdf) |
      {2'h0, $past(i_instr.op) == halfcarry_set_op, 5'h00}))
    else $error("half carry flag op wrong");

  signtest_ops_a: assert property ( // see RQ16
    accept && (i_instr.op == signtest_set_op || i_instr.op == signtest_clear_op) |=>
      o_status == (($past(o_status) & 8'hef) |
      {3'h0, $past(i_instr.op) == signtest_set_op, 4'h0}))
    else $error("signed test flag op wrong");

  sleep_enter_a: assert property ( // see RQ17
    issued(op_sleep) |=> o_sleep && !o_ready && $stable(o_status))
    else $error("sleep entry wrong");

  sleep_hold_a: assert property ( // see RQ17
    o_sleep && !i_wake |=> o_sleep && !o_ready)
    else $error("left sleep without wake");
endmodule

// ### tb/mcu_bit_and_store_instr_exec_tb_top.sv
`timescale 1ns/100ps
module mcu_bit_and_store_instr_exec_tb_top;
  import exec_pkg::*;

  logic i_clock;
  logic i_rst;
  logic i_issue;
  instr_t i_instr;
  logic o_ready;
  logic [7:0] i_mem_rdata;
  mem_req_t o_mem;
  io_bit_t o_io;
  logic i_wake;
  logic o_sleep;
  logic [7:0] o_status;
  logic [15:0] o_sp;
  logic [4:0] i_peek_sel;
  logic [7:0] o_peek_data;

  int fails;
  int n_tests;
  int cycles;
  logic [7:0] status_exp;
  logic [15:0] sp0;

  mcu_bit_and_store_instr_exec DUT (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_issue(i_issue),
    .i_instr(i_instr),
    .o_ready(o_ready),
    .i_mem_rdata(i_mem_rdata),
    .o_mem(o_mem),
    .o_io(o_io),
    .i_wake(i_wake),
    .o_sleep(o_sleep),
    .o_status(o_status),
    .o_sp(o_sp),
    .i_peek_sel(i_peek_sel),
    .o_peek_data(o_peek_data)
  );

  initial begin
    i_clock = 1'b0;
    i_rst = 1'b1;
    i_issue = 1'b0;
    i_instr = '0;
    i_mem_rdata = 8'h00;
    i_wake = 1'b0;
    i_peek_sel = 5'h00;
    fails = 0;
    n_tests = 0;
    cycles = 0;
  end

  always #2.5 i_clock = ~i_clock;

  task automatic test_done();
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hang guard, the full run needs well under 1000 cycles
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      test_done();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // offer one instruction, return just after the taking edge
  task automatic exec(input op_t op, input logic [4:0] dst, input logic [4:0] src,
                      input logic [2:0] b, input logic [5:0] disp, input logic [15:0] addr);
    instr_t ins;
    ins.op = op;
    ins.dst = dst;
    ins.src = src;
    ins.bitsel = b;
    ins.disp = disp;
    ins.addr = addr;
    @(posedge i_clock);
    i_issue <= 1'b1;
    i_instr <= ins;
    @(posedge i_clock);
    i_issue <= 1'b0;
    #1;
  endtask

  // edge that ends the second cycle of a two-cycle op: strobes gone, ready back
  task automatic tail2();
    @(posedge i_clock);
    #1;
    check(o_ready, 1);
    check({o_mem.wr, o_mem.rd, o_io.we}, 3'b000);
    check(o_status, status_exp);
  endtask

  task automatic peek_chk(input logic [4:0] r, input logic [7:0] exp);
    @(posedge i_clock);
    i_peek_sel <= r;
    @(posedge i_clock);
    @(posedge i_clock);
    #1;
    check(o_peek_data, exp);
  endtask

  // registers are only reachable through pop
  task automatic load(input logic [4:0] r, input logic [7:0] v);
    sp0 = o_sp;
    @(posedge i_clock);
    i_mem_rdata <= v;
    exec(op_pop, r, 5'h00, 3'd0, 6'h00, 16'h0000);
    check(o_mem.rd, 1);
    check(o_mem.wr, 0);
    check(o_mem.addr, sp0 + 16'h0001);
    check(o_sp, sp0 + 16'h0001);
    check(o_ready, 0);
    check(o_status, status_exp);
    tail2();
    peek_chk(r, v);
  endtask

  task automatic t_stores();
    exec(store_displaced, 5'h00, 5'h05, 3'd0, 6'h3f, 16'h0000);
    check(o_mem, {1'b1, 1'b0, 16'h024f, 8'h81});
    check(o_ready, 0);
    check(o_status, status_exp);
    tail2();
    exec(store_direct, 5'h00, 5'h06, 3'd0, 6'h00, 16'hfffe);
    check(o_mem, {1'b1, 1'b0, 16'hfffe, 8'h01});
    check(o_ready, 0);
    tail2();
    sp0 = o_sp;
    exec(op_push, 5'h00, 5'h06, 3'd0, 6'h00, 16'h0000);
    check(o_mem, {1'b1, 1'b0, sp0, 8'h01});
    check(o_sp, sp0 - 16'h0001);
    check(o_status, status_exp);
    tail2();
  endtask

  task automatic t_io();
    exec(io_bit_set_op, 5'h00, 5'h00, 3'd7, 6'h00, 16'h003f);
    check(o_io, {1'b1, 6'h3f, 3'd7, 1'b1});
    check(o_ready, 0);
    tail2();
    // upper address bits must not leak into the io address
    exec(io_bit_clear_op, 5'h00, 5'h00, 3'd0, 6'h00, 16'hffc0);
    check(o_io, {1'b1, 6'h00, 3'd0, 1'b0});
    check(o_status, status_exp);
    tail2();
  endtask

  task automatic t_flags();
    op_t ops[8];
    int pos[8];
    logic val[8];
    ops = '{overflow_set_op, halfcarry_set_op, signtest_set_op, overflow_clear_op,
            halfcarry_clear_op, signtest_clear_op, halfcarry_set_op, signtest_set_op};
    pos = '{3, 5, 4, 3, 5, 4, 5, 4};
    val = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    for (int k = 0; k < 8; k++) begin
      exec(ops[k], 5'h00, 5'h00, 3'd0, 6'h00, 16'h0000);
      status_exp[pos[k]] = val[k];
      check(o_status, status_exp);
    end
  endtask

  task automatic t_shifts();
    op_t sh[5];
    logic [7:0] d;
    logic [7:0] r;
    logic co;
    sh = '{shift_left_logical, shift_right_logical, rotate_left_carry,
           rotate_right_carry, shift_right_arith};
    for (int i = 0; i < 5; i++) begin
      for (int c = 0; c < 2; c++) begin
        d = (c == 1) ? 8'h41 : 8'h80;
        load(5'd8, d);
        exec((c == 1) ? flag_set_op : flag_clear_op, 5'h00, 5'h00, 3'd0, 6'h00, 16'h0000);
        status_exp[0] = c[0];
        check(o_status, status_exp);
        case (i)
          0: r = {d[6:0], 1'b0};
          1: r = {1'b0, d[7:1]};
          2: r = {d[6:0], c[0]};
          3: r = {c[0], d[7:1]};
          default: r = {d[7], d[7:1]};
        endcase
        co = (i == 0 || i == 2) ? d[7] : d[0];
        exec(sh[i], 5'd8, 5'h00, 3'd0, 6'h00, 16'h0000);
        status_exp[0] = co;
        status_exp[1] = (r == 8'h00);
        status_exp[2] = r[7];
        status_exp[3] = r[7] ^ co;
        check(o_status, status_exp);
        peek_chk(5'd8, r);
      end
    end
  endtask

  task automatic t_bits();
    exec(bit_to_flag_op, 5'h00, 5'h05, 3'd7, 6'h00, 16'h0000);
    status_exp[6] = 1'b1;
    check(o_status, status_exp);
    exec(bit_to_flag_op, 5'h00, 5'h05, 3'd1, 6'h00, 16'h0000);
    status_exp[6] = 1'b0;
    check(o_status, status_exp);
    exec(bit_to_flag_op, 5'h00, 5'h05, 3'd0, 6'h00, 16'h0000);
    status_exp[6] = 1'b1;
    check(o_status, status_exp);
    exec(flag_to_bit_op, 5'd9, 5'h00, 3'd3, 6'h00, 16'h0000);
    check(o_status, status_exp);
    peek_chk(5'd9, 8'h08);
  endtask

  task automatic t_sleep();
    exec(op_sleep, 5'h00, 5'h00, 3'd0, 6'h00, 16'h0000);
    check(o_sleep, 1);
    check(o_ready, 0);
    check(o_status, status_exp);
    // an offer while asleep is dropped; v is set here, so a taken clear would show
    exec(overflow_clear_op, 5'h00, 5'h00, 3'd0, 6'h00, 16'h0000);
    check(o_sleep, 1);
    check(o_status, status_exp);
    @(posedge i_clock);
    i_wake <= 1'b1;
    @(posedge i_clock);
    i_wake <= 1'b0;
    #1;
    check(o_sleep, 0);
    check(o_ready, 1);
    exec(overflow_clear_op, 5'h00, 5'h00, 3'd0, 6'h00, 16'h0000);
    status_exp[3] = 1'b0;
    check(o_status, status_exp);
  endtask

  initial begin
    status_exp = 8'h00;
    repeat (7) @(posedge i_clock);
    #1;
    check({o_ready, o_sleep, o_mem, o_io}, {1'b1, 1'b0, 26'h0, 11'h0});
    check({o_status, o_sp, o_peek_data}, {8'h00, 16'h007f, 8'h00});
    @(posedge i_clock);
    i_rst <= 1'b0;
    load(5'd30, 8'h10);
    load(5'd31, 8'h02);
    load(5'd5, 8'h81);
    load(5'd6, 8'h01);
    t_stores();
    load(5'd7, 8'h5a);
    t_io();
    t_flags();
    t_shifts();
    t_bits();
    t_sleep();
    test_done();
  end
endmodule
